// [hdl/adc_conversion_sequencer.v]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
// converter sequencing, register file and event interrupt
module adc_conversion_sequencer #(
  parameter AW = 8,
  parameter DW = 8
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [AW-1:0] reg_addr,
  input wire [DW-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [DW-1:0] reg_rdata,
  input wire comp_above,
  output reg sample_hold,
  output wire [DW-1:0] dac_code,
  output reg [4:0] channel_select,
  output reg converter_power_down,
  output reg conversion_irq
);

  // control fields written by software
  reg continuous_convert;
  reg conversion_irq_enable;
  reg [4:0] input_selector;
  // completion flag, hardware set, result read clears
  reg conversion_complete_flag;
  // last delivered code
  reg [DW-1:0] result;
  // result not yet read by software
  reg result_unread;
  // sticky event bits and their enables
  reg [`ADC_EV_WIDTH-1:0] event_status;
  reg [`ADC_EV_WIDTH-1:0] event_enable;

  // next values
  reg next_complete;
  reg [`ADC_EV_WIDTH-1:0] next_event_status;
  reg [DW-1:0] next_rdata;

  // address decode strobes
  wire wr_control;
  wire wr_clear;
  wire wr_enable;
  wire rd_result;

  // timer signals
  wire busy;
  wire [3:0] count;
  wire last;

  // conversion control
  wire powered_down;
  wire start_conv;
  wire stop_conv;
  wire begin_trial;
  wire decide;
  wire [DW-1:0] trial;

  // event pulses
  wire done_event;
  wire overwrite_event;

  // decode of the plain register port
  assign wr_control = reg_wr & (reg_addr == `ADC_OFS_CONTROL_STATUS);
  assign wr_clear = reg_wr & (reg_addr == `ADC_OFS_EVENT_CLEAR);
  assign wr_enable = reg_wr & (reg_addr == `ADC_OFS_EVENT_ENABLE);
  assign rd_result = reg_rd & (reg_addr == `ADC_OFS_RESULT);

  // power-down code in the new or held selector
  assign powered_down = wr_control ?
    (reg_wdata[`ADC_CS_SEL_HI:`ADC_CS_SEL_LO] == `ADC_SEL_POWER_DOWN) :
    (input_selector == `ADC_SEL_POWER_DOWN);

  // any control write with a live selector restarts at the very next edge
  // continuous mode chains the next conversion straight on
  assign start_conv = ~powered_down &
    (wr_control | (last & continuous_convert));

  // power-down aborts a running conversion
  assign stop_conv = powered_down;

  // the first trial is loaded at the end of sampling
  assign begin_trial = busy & (count == `ADC_SAMPLE_LAST);

  // one bit decided in each of eight cycles
  assign decide = busy & (count >= `ADC_DECIDE_FIRST) &
    (count <= `ADC_DECIDE_LAST);

  // result delivered in the sixteenth cycle
  assign done_event = last;

  // unread result about to be replaced
  assign overwrite_event = last & result_unread & ~rd_result;

  // sixteen cycle conversion clock, never gated by wait
  conversion_timer #(
    .CYCLES(`ADC_CONV_CYCLES),
    .CW(4)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .start(start_conv),
    .stop(stop_conv),
    .busy(busy),
    .count(count),
    .last(last)
  );

  // approximation register drives the reference code
  sar_register #(
    .W(DW)
  ) u_sar (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .begin_conv(begin_trial),
    .decide(decide),
    .comp_above(comp_above),
    .trial(trial)
  );

  // trial code goes out to the front end
  assign dac_code = trial;

  // control fields written by software
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      continuous_convert <= 1'b0;
      conversion_irq_enable <= 1'b0;
      input_selector <= `ADC_SEL_RESET;
    end
    else if (wr_control)
    begin
      continuous_convert <= reg_wdata[`ADC_CS_CONTINUOUS_BIT];
      conversion_irq_enable <= reg_wdata[`ADC_CS_IRQ_EN_BIT];
      input_selector <= reg_wdata[`ADC_CS_SEL_HI:`ADC_CS_SEL_LO];
    end
  end

  // front-end controls, registered
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_hold <= 1'b0;
      channel_select <= `ADC_SEL_RESET;
      converter_power_down <= 1'b1;
    end
    else
    begin
      // track during cycles 0 to 6
      sample_hold <= start_conv |
        (busy & ~stop_conv & ~last & (count < `ADC_SAMPLE_LAST));
      // selected channel follows the control field
      if (wr_control)
        channel_select <= reg_wdata[`ADC_CS_SEL_HI:`ADC_CS_SEL_LO];
      // converter analog power off on all-ones selector
      converter_power_down <= powered_down;
    end
  end

  // result register, overwritten at each end
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      result <= `ADC_BYTE_ZERO;
      result_unread <= 1'b0;
    end
    else
    begin
      if (last)
      begin
        // replace regardless of whether it was read
        result <= trial;
        result_unread <= 1'b1;
      end
      else if (rd_result)
      begin
        result_unread <= 1'b0;
      end
    end
  end

  // completion flag next value
  always @*
  begin
    next_complete = conversion_complete_flag;
    if (conversion_irq_enable)
    begin
      // flag held low while the interrupt reports completion
      next_complete = 1'b0;
    end
    else if (done_event)
    begin
      // set wins over a same-cycle read
      next_complete = 1'b1;
    end
    else if (rd_result)
    begin
      // reading the result clears it
      next_complete = 1'b0;
    end
  end

  // completion flag register
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      conversion_complete_flag <= 1'b0;
    else
      conversion_complete_flag <= next_complete;
  end

  // sticky event bits, set wins over clear
  always @*
  begin
    next_event_status = event_status;
    if (wr_clear)
      next_event_status = next_event_status & ~reg_wdata[`ADC_EV_WIDTH-1:0];
    if (done_event & conversion_irq_enable)
      next_event_status[`ADC_EV_DONE_BIT] = 1'b1;
    if (overwrite_event)
      next_event_status[`ADC_EV_OVERWRITE_BIT] = 1'b1;
  end

  // event status, enable and interrupt line
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      event_status <= `ADC_EV_ZERO;
      event_enable <= `ADC_EV_ZERO;
      conversion_irq <= 1'b0;
    end
    else
    begin
      event_status <= next_event_status;
      if (wr_enable)
        event_enable <= reg_wdata[`ADC_EV_WIDTH-1:0];
      // level request, also the wake request out of wait
      conversion_irq <= |(next_event_status &
        (wr_enable ? reg_wdata[`ADC_EV_WIDTH-1:0] : event_enable));
    end
  end

  // read data mux, unmapped reads return zero
  always @*
  begin
    next_rdata = `ADC_BYTE_ZERO;
    case (reg_addr)
      `ADC_OFS_CONTROL_STATUS:
      begin
        next_rdata[`ADC_CS_COMPLETE_BIT] = conversion_complete_flag;
        next_rdata[`ADC_CS_IRQ_EN_BIT] = conversion_irq_enable;
        next_rdata[`ADC_CS_CONTINUOUS_BIT] = continuous_convert;
        next_rdata[`ADC_CS_SEL_HI:`ADC_CS_SEL_LO] = input_selector;
      end
      `ADC_OFS_RESULT:
        next_rdata = result;
      `ADC_OFS_EVENT_STATUS:
        next_rdata[`ADC_EV_WIDTH-1:0] = event_status;
      `ADC_OFS_EVENT_ENABLE:
        next_rdata[`ADC_EV_WIDTH-1:0] = event_enable;
      default:
        next_rdata = `ADC_BYTE_ZERO;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= `ADC_BYTE_ZERO;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= `ADC_BYTE_ZERO;
  end

  // single mode: timer idles after last since no restart
  // (start_conv only chains when continuous_convert is set)

endmodule

// [hdl/adc_seq_regs.vh]
// Behaviour
// - each conversion lasts sixteen converter clocks
// - control write with a live selector starts conversion next edge
// - continuous mode reconverts, reloads result each time
// - new result overwrites unread old result
// - conversions repeat until continuous bit cleared
// - complete flag set, cleared by result read
// - interrupt enable raises request every conversion while the done event is enabled
// - complete flag stays zero while interrupts enabled
// - converter runs normally during wait mode
// - enabled request can wake the system
// - selector all ones powers converter down
// - top reference ff, bottom 00, saturating
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// register byte addresses
`define ADC_OFS_CONTROL_STATUS 8'h3c
`define ADC_OFS_RESULT 8'h3d
`define ADC_OFS_EVENT_STATUS 8'h3e
`define ADC_OFS_EVENT_CLEAR 8'h3f
`define ADC_OFS_EVENT_ENABLE 8'h40

// control/status field positions
`define ADC_CS_COMPLETE_BIT 7
`define ADC_CS_IRQ_EN_BIT 6
`define ADC_CS_CONTINUOUS_BIT 5
`define ADC_CS_SEL_HI 4
`define ADC_CS_SEL_LO 0

// event status bit positions
`define ADC_EV_DONE_BIT 0
`define ADC_EV_OVERWRITE_BIT 1
`define ADC_EV_WIDTH 2

// reset values and power-down selector code
`define ADC_SEL_RESET 5'h1f
`define ADC_SEL_POWER_DOWN 5'h1f
`define ADC_BYTE_ZERO 8'h00
`define ADC_EV_ZERO 2'h0

// conversion timing, in converter clock cycles
`define ADC_CONV_CYCLES 16
`define ADC_SAMPLE_LAST 4'h6
`define ADC_DECIDE_FIRST 4'h7
`define ADC_DECIDE_LAST 4'he
`define ADC_COUNT_ZERO 4'h0
`define ADC_COUNT_ONE 4'h1

`endif

// [hdl/conversion_timer.v]
`timescale 1ns/1ps
// counts the cycles of one conversion
module conversion_timer #(
  parameter CYCLES = 16,
  parameter CW = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire start,
  input wire stop,
  output reg busy,
  output reg [CW-1:0] count,
  output wire last
);

  // final cycle of a conversion, cut to the counter width on purpose
  localparam integer LAST_INT = CYCLES - 1;
  localparam [CW-1:0] COUNT_LAST = LAST_INT[CW-1:0];

  assign last = busy & (count == COUNT_LAST);

  // start wins over stop and over natural end
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busy <= 1'b0;
      count <= {CW{1'b0}};
    end
    else if (start)
    begin
      // restart from cycle zero
      busy <= 1'b1;
      count <= {CW{1'b0}};
    end
    else if (stop || last)
    begin
      // abort or completed
      busy <= 1'b0;
      count <= {CW{1'b0}};
    end
    else if (busy)
    begin
      count <= count + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [hdl/sar_register.v]
`timescale 1ns/1ps
// successive approximation trial register
module sar_register #(
  parameter W = 8
) (
  input wire sys_clk,
  input wire rst_b,
  input wire begin_conv,
  input wire decide,
  input wire comp_above,
  output reg [W-1:0] trial
);

  // bit currently under test
  reg [W-1:0] mask;
  // trial with current bit kept or dropped
  wire [W-1:0] decided;

  // comparator high keeps the bit, so full input gives all ones
  assign decided = comp_above ? trial : (trial & ~mask);

  // one bit decided per decide cycle, msb first
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      trial <= {W{1'b0}};
      mask <= {W{1'b0}};
    end
    else if (begin_conv)
    begin
      // midscale first trial
      trial <= {1'b1, {(W-1){1'b0}}};
      mask <= {1'b1, {(W-1){1'b0}}};
    end
    else if (decide && (mask != {W{1'b0}}))
    begin
      // keep decision, offer next lower bit
      trial <= decided | (mask >> 1);
      mask <= mask >> 1;
    end
  end

endmodule

// [verification/adc_seq_properties.sv]
`timescale 1ns/1ps
// watches the sequencer ports
module adc_seq_checker (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire sample_hold,
  input wire [7:0] dac_code,
  input wire [4:0] channel_select,
  input wire converter_power_down,
  input wire conversion_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // control write with a live selector
  sequence go_s;
    reg_wr && reg_addr == 8'h3c && reg_wdata[4:0] != 5'h1f;
  endsequence
  // seven tracking cycles, then the first trial
  sequence track_s;
    sample_hold[*7] ##1 (!sample_hold && dac_code == 8'h80);
  endsequence
  start_track_a: assert property (go_s |=> track_s)
    else $error("tracking phase wrong after start");
  pd_sel_a: assert property (converter_power_down |-> channel_select == 5'h1f && !sample_hold)
    else $error("powered down but active");
  sel_copy_a: assert property (reg_wr && reg_addr == 8'h3c |=>
    channel_select == $past(reg_wdata[4:0]))
    else $error("selector not copied");
  pd_keep_a: assert property (converter_power_down && !(reg_wr && reg_addr == 8'h3c) |=>
    converter_power_down)
    else $error("woke without a write");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  irq_time_a: assert property ($rose(conversion_irq) && !$past(reg_wr && reg_addr == 8'h40)
    |-> $past(sample_hold, 10) && !$past(sample_hold, 9))
    else $error("request not at conversion end");
  irq_fall_a: assert property ($fell(conversion_irq) |->
    $past(reg_wr && (reg_addr == 8'h3f || reg_addr == 8'h40)))
    else $error("request dropped by itself");
  ctl_read_a: assert property (reg_rd && reg_addr == 8'h3c |=>
    reg_rdata[4:0] == channel_select && !(reg_rdata[7] && reg_rdata[6]))
    else $error("control read wrong");
endmodule
bind adc_conversion_sequencer adc_seq_checker chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .sample_hold, .dac_code, .channel_select,
  .converter_power_down, .conversion_irq);

// [verification/analog_front_end.sv]
`timescale 1ns/1ps
// front end: holds the level, answers trial codes
module analog_front_end (
  input wire sys_clk,
  input wire sample_hold,
  input wire [7:0] dac_code,
  input wire converter_power_down,
  input wire signed [31:0] vin,
  output wire comp_above
);
  reg signed [31:0] held = 0; // held level
  reg noise = 1'b0; // idle pattern
  // track while sampling, toggle always
  always @(posedge sys_clk)
  begin
    noise <= ~noise;
    if (sample_hold)
      held <= vin;
  end
  // saturating compare, garbage when off
  assign comp_above = converter_power_down ? noise : held >= $signed({24'h0, dac_code});
endmodule

// [verification/test_adc_conversion_sequencer.sv]
`timescale 1ns/1ps
// sequencer bench
module test_adc_conversion_sequencer;
  reg sys_clk = 1'b0; // converter clock
  reg rst_b = 1'b0; // low active reset
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire comp_above;
  wire sample_hold;
  wire converter_power_down;
  wire conversion_irq;
  wire [7:0] dac_code;
  wire [4:0] channel_select;
  integer vin = 0; // analog level
  integer bad_count = 0;
  integer total_checks = 0;
  integer cyc = 0; // cycle count
  reg rd_seen = 1'b0; // read strobe one back
  reg [7:0] exp_q[$]; // expected reads
  reg [4:0] sel; // channel
  reg [7:0] v; // expected code
  integer i;
  adc_conversion_sequencer dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .comp_above, .sample_hold, .dac_code, .channel_select,
    .converter_power_down, .conversion_irq);
  analog_front_end afe (.sys_clk, .sample_hold, .dac_code, .converter_power_down, .vin,
    .comp_above);
  // clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  // compare and count
  task check(input [7:0] seen, input [7:0] want);
  begin
    total_checks = total_checks + 1;
    if (seen !== want)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  end
  endtask
  // verdict
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // one strobe cycle, read notes its expectation
  task bus(input w, input [7:0] a, input [7:0] d, input [7:0] e);
  begin
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge sys_clk);
  end
  endtask
  // bus quiet
  task idle(input integer n);
  begin
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  end
  endtask
  // read data checked against oldest note, plus timeout
  always @(posedge sys_clk)
  begin
    if (rd_seen)
      check(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count = bad_count + 1;
      end_sim;
    end
  end
  // main sequence
  initial
  begin
    void'($urandom(36690));
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(0, 8'h3c, 0, 8'h1f);
    bus(0, 8'h3e, 0, 8'h00);
    bus(0, 8'h40, 0, 8'h00);
    bus(1, 8'h3d, 8'h5a, 0);
    bus(0, 8'h77, 0, 8'h00);
    bus(0, 8'h3f, 0, 8'h00);
    idle(1);
    $display("reset test done");
    for (i = 0; i < 5; i = i + 1)
    begin
      sel = 5'($urandom % 31);
      vin = (i == 0) ? 300 : (i == 1) ? 255 : (i == 2) ? 0 : (i == 3) ? -20 : $urandom % 256;
      v = (vin > 255) ? 8'hff : (vin < 0) ? 8'h00 : vin[7:0];
      bus(1, 8'h3c, {3'b000, sel}, 0);
      idle(15);
      bus(0, 8'h3c, 0, {3'b000, sel});
      bus(0, 8'h3c, 0, {3'b100, sel});
      bus(0, 8'h3d, 0, v);
      bus(0, 8'h3c, 0, {3'b000, sel});
      idle(20);
      bus(0, 8'h3c, 0, {3'b000, sel});
      check({3'b000, channel_select}, {3'b000, sel});
    end
    $display("single test done");
    vin = 40;
    bus(1, 8'h3c, {3'b001, sel}, 0);
    idle(16);
    vin = $urandom % 256;
    idle(16);
    bus(0, 8'h3d, 0, vin[7:0]);
    vin = 200;
    idle(20);
    bus(1, 8'h3c, {3'b000, sel}, 0);
    idle(40);
    bus(0, 8'h3d, 0, 8'hc8);
    idle(40);
    bus(0, 8'h3c, 0, {3'b000, sel});
    bus(0, 8'h3e, 0, 8'h02);
    bus(1, 8'h3f, 8'h02, 0);
    $display("continuous test done");
    bus(1, 8'h40, 8'h01, 0);
    bus(1, 8'h3c, {3'b010, sel}, 0);
    idle(16);
    #1 check({7'h00, conversion_irq}, 8'h01);
    bus(0, 8'h3c, 0, {3'b010, sel});
    bus(0, 8'h3e, 0, 8'h01);
    bus(1, 8'h3f, 8'h01, 0);
    idle(1);
    #1 check({7'h00, conversion_irq}, 8'h00);
    bus(1, 8'h40, 8'h00, 0);
    bus(1, 8'h3c, {3'b010, sel}, 0);
    idle(20);
    #1 check({7'h00, conversion_irq}, 8'h00);
    bus(0, 8'h3e, 0, 8'h03);
    bus(1, 8'h40, 8'h01, 0);
    idle(1);
    #1 check({7'h00, conversion_irq}, 8'h01);
    bus(1, 8'h3f, 8'h01, 0);
    $display("interrupt test done");
    vin = 10;
    bus(1, 8'h3c, {3'b000, sel}, 0);
    idle(10);
    vin = 99;
    bus(1, 8'h3c, {3'b000, sel}, 0);
    idle(16);
    bus(0, 8'h3d, 0, 8'h63);
    bus(1, 8'h3c, {3'b000, sel}, 0);
    idle(10);
    bus(1, 8'h3c, 8'h1f, 0);
    idle(20);
    #1 check({7'h00, converter_power_down}, 8'h01);
    bus(0, 8'h3c, 0, 8'h1f);
    idle(3);
    $display("abort test done");
    end_sim;
  end
endmodule
